// ---- src/reset_cause_recorder.sv ----
// Reset cause register, watchdog enable, power-save mode and interrupt logic
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "rcr_defs.svh"
module reset_cause_recorder
   import rcr_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          rstn,
   input  wire rcr_bus_type   bus,
   output logic [15:0]        rdata,
   input  wire rcr_event_type events,
   input  wire logic          masterClearPin,
   input  wire logic [1:0]    watchdogConfigField,
   input  wire logic          enterSleep,
   input  wire logic          enterIdle,
   input  wire logic          enabledInterrupt,
   output logic               irq,
   output logic               wdtRun,
   output logic               sysClockRun,
   output logic               cpuRun,
   output logic               coreRegStandby,
   output logic               flashRegStandby,
   output logic               deviceReset
);
   rcr_state_type s;
   rcr_state_type next_s;
   logic [15:0]   setBits;
   logic          pinEvent;
   logic          causeWrite;
   logic          wakeEvent;

   ////////////////////////////////////////////////////////////////////////////////
   // Event collection
   always_comb begin
      pinEvent = s.pinSync[1] | events.masterClear;
      causeWrite = bus.wr && bus.addr == `RCR_ADDR_CAUSE;
      setBits = 16'h0000;
      setBits[`RCR_BIT_TRAP]     = events.trapConflict;
      setBits[`RCR_BIT_ILLEGAL]  = events.illegalOp;
      setBits[`RCR_BIT_CFG_MIS]  = events.configMismatch;
      setBits[`RCR_BIT_PIN]      = pinEvent;
      setBits[`RCR_BIT_SOFT]     = events.resetInstr;
      setBits[`RCR_BIT_WDT_TO]   = events.watchdogTimeout;
      setBits[`RCR_BIT_BROWNOUT] = events.brownout;
      setBits[`RCR_BIT_POWERON]  = events.powerOn;
      wakeEvent = enabledInterrupt | events.watchdogTimeout | (|setBits);
      if (s.mode == RCR_SLEEP && wakeEvent) begin
         setBits[`RCR_BIT_SLEEP] = 1'b1;
      end
      if (s.mode == RCR_IDLE && wakeEvent) begin
         setBits[`RCR_BIT_IDLE] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_s = s;
      next_s.pinSync = {s.pinSync[0], masterClearPin};
      next_s.porDone = 1'b1;
      next_s.rdata = 16'h0000;
      if (bus.rd) begin
         case (bus.addr)
            `RCR_ADDR_CAUSE:    next_s.rdata = s.cause;
            `RCR_ADDR_IRQ_STAT: next_s.rdata = s.irqStat;
            `RCR_ADDR_IRQ_MASK: next_s.rdata = s.irqMask;
            `RCR_ADDR_MODE:     next_s.rdata = {14'h0000, s.mode};
            default:            next_s.rdata = 16'h0000;
         endcase
      end
      // Software writes to the cause register are masked stores; no reset follows
      if (bus.wr && bus.addr == `RCR_ADDR_CAUSE) begin
         next_s.cause = bus.wdata & `RCR_CAUSE_WMASK;
      end
      next_s.cause = next_s.cause | setBits;
      if (bus.wr && bus.addr == `RCR_ADDR_IRQ_MASK) begin
         next_s.irqMask = bus.wdata & `RCR_CAUSE_WMASK;
      end
      if (bus.wr && bus.addr == `RCR_ADDR_IRQ_STAT) begin
         next_s.irqStat = s.irqStat & ~bus.wdata;
      end
      next_s.irqStat = next_s.irqStat | setBits;
      next_s.irq = |(next_s.irqStat & next_s.irqMask);
      // Power-save mode
      case (s.mode)
         RCR_RUN: begin
            if (enterSleep) begin
               next_s.mode = RCR_SLEEP;
            end else if (enterIdle) begin
               next_s.mode = RCR_IDLE;
            end
         end
         RCR_IDLE, RCR_SLEEP: begin
            if (wakeEvent) begin
               next_s.mode = RCR_RUN;
            end
         end
         default: next_s.mode = RCR_RUN;
      endcase
      next_s.sysClockRun = next_s.mode != RCR_SLEEP;
      next_s.cpuRun = next_s.mode == RCR_RUN;
      next_s.coreRegStandby = next_s.mode == RCR_SLEEP
                              && !next_s.cause[`RCR_BIT_CORE_REG];
      next_s.flashRegStandby = next_s.mode == RCR_SLEEP
                               && !next_s.cause[`RCR_BIT_FLASH_REG];
      next_s.wdtRun = watchdogConfigField == `RCR_WDT_CFG_ON
                      || next_s.cause[`RCR_BIT_WDT_EN];
      next_s.deviceReset = events.trapConflict | events.illegalOp
                           | events.configMismatch | pinEvent | events.resetInstr
                           | events.watchdogTimeout | events.brownout;
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         s <= '0;
         s.cause <= `RCR_CAUSE_POR;
         s.irqStat <= `RCR_CAUSE_POR;
         s.mode <= RCR_RUN;
         s.sysClockRun <= 1'b1;
         s.cpuRun <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.rdata;
   assign irq = s.irq;
   assign wdtRun = s.wdtRun;
   assign sysClockRun = s.sysClockRun;
   assign cpuRun = s.cpuRun;
   assign coreRegStandby = s.coreRegStandby;
   assign flashRegStandby = s.flashRegStandby;
   assign deviceReset = s.deviceReset;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   trap_flag_set_a: assert property (@(posedge clock) disable iff (!rstn)
      events.trapConflict |=> s.cause[`RCR_BIT_TRAP])
      else $error("trap flag not set");
   illegal_flag_set_a: assert property (@(posedge clock) disable iff (!rstn)
      events.illegalOp |=> s.cause[`RCR_BIT_ILLEGAL] && deviceReset)
      else $error("illegal op flag or reset missing");
   mismatch_flag_set_a: assert property (@(posedge clock) disable iff (!rstn)
      events.configMismatch |=> s.cause[`RCR_BIT_CFG_MIS])
      else $error("mismatch flag not set");
   pin_flag_set_a: assert property (@(posedge clock) disable iff (!rstn)
      $rose(masterClearPin) |-> ##3 s.cause[`RCR_BIT_PIN])
      else $error("pin flag not set");
   soft_flag_set_a: assert property (@(posedge clock) disable iff (!rstn)
      events.resetInstr |=> s.cause[`RCR_BIT_SOFT])
      else $error("soft reset flag not set");
   wdt_enable_follow_a: assert property (@(posedge clock) disable iff (!rstn)
      s.porDone && watchdogConfigField != `RCR_WDT_CFG_ON
      |=> wdtRun == s.cause[`RCR_BIT_WDT_EN])
      else $error("watchdog enable mismatch");
   wdt_timeout_set_a: assert property (@(posedge clock) disable iff (!rstn)
      events.watchdogTimeout |=> s.cause[`RCR_BIT_WDT_TO])
      else $error("timeout flag not set");
   soft_write_a: assert property (@(posedge clock) disable iff (!rstn)
      bus.wr && bus.addr == 4'h0 && events == '0 && !s.pinSync[1]
      |=> s.cause == (($past(bus.wdata) & 16'hcbff) | (s.cause & 16'h000c))
          && !deviceReset)
      else $error("software write wrong or caused reset");
   wdt_forced_a: assert property (@(posedge clock) disable iff (!rstn)
      watchdogConfigField == 2'h3 |=> wdtRun)
      else $error("watchdog not forced on");
   sleep_clock_a: assert property (@(posedge clock) disable iff (!rstn)
      s.mode == RCR_SLEEP |-> !sysClockRun && !cpuRun)
      else $error("clock runs in sleep");
   wake_exit_a: assert property (@(posedge clock) disable iff (!rstn)
      s.mode != RCR_RUN && enabledInterrupt |=> s.mode == RCR_RUN)
      else $error("no wake on interrupt");
   brownout_set_a: assert property (@(posedge clock) disable iff (!rstn)
      events.brownout |=> s.cause[`RCR_BIT_BROWNOUT])
      else $error("brownout flag not set");
   regulator_standby_a: assert property (@(posedge clock) disable iff (!rstn)
      s.mode == RCR_SLEEP |-> coreRegStandby == !s.cause[`RCR_BIT_CORE_REG])
      else $error("core regulator standby wrong");

   // Flags stay clear without their event or a cause write
   trap_flag_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      !events.trapConflict && !causeWrite && !s.cause[`RCR_BIT_TRAP]
      |=> !s.cause[`RCR_BIT_TRAP])
      else $error("trap flag set without event");
   illegal_flag_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      !events.illegalOp && !causeWrite && !s.cause[`RCR_BIT_ILLEGAL]
      |=> !s.cause[`RCR_BIT_ILLEGAL])
      else $error("illegal op flag set without event");
   mismatch_flag_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      !events.configMismatch && !causeWrite && !s.cause[`RCR_BIT_CFG_MIS]
      |=> !s.cause[`RCR_BIT_CFG_MIS])
      else $error("mismatch flag set without event");
   pin_flag_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      !events.masterClear && !s.pinSync[1] && !causeWrite && !s.cause[`RCR_BIT_PIN]
      |=> !s.cause[`RCR_BIT_PIN])
      else $error("pin flag set without event");
   soft_flag_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      !events.resetInstr && !causeWrite && !s.cause[`RCR_BIT_SOFT]
      |=> !s.cause[`RCR_BIT_SOFT])
      else $error("soft reset flag set without event");
   timeout_flag_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      !events.watchdogTimeout && !causeWrite && !s.cause[`RCR_BIT_WDT_TO]
      |=> !s.cause[`RCR_BIT_WDT_TO])
      else $error("timeout flag set without event");
   brownout_flag_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      !events.brownout && !causeWrite && !s.cause[`RCR_BIT_BROWNOUT]
      |=> !s.cause[`RCR_BIT_BROWNOUT])
      else $error("brownout flag set without event");
   poweron_flag_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      !events.powerOn && !causeWrite && !s.cause[`RCR_BIT_POWERON]
      |=> !s.cause[`RCR_BIT_POWERON])
      else $error("power-on flag set without event");

   // Flags set on their event and stay set until a cause write
   poweron_set_a: assert property (@(posedge clock) disable iff (!rstn)
      events.powerOn |=> s.cause[`RCR_BIT_POWERON])
      else $error("power-on flag not set");
   pin_event_set_a: assert property (@(posedge clock) disable iff (!rstn)
      events.masterClear |=> s.cause[`RCR_BIT_PIN])
      else $error("pin flag not set by event");
   flags_sticky_a: assert property (@(posedge clock) disable iff (!rstn)
      !causeWrite |=> (s.cause & $past(s.cause)) == $past(s.cause))
      else $error("flag dropped without write");
   sleep_wake_flag_a: assert property (@(posedge clock) disable iff (!rstn)
      s.mode == RCR_SLEEP && enabledInterrupt |=> s.cause[`RCR_BIT_SLEEP])
      else $error("sleep wake flag not set");
   idle_wake_flag_a: assert property (@(posedge clock) disable iff (!rstn)
      s.mode == RCR_IDLE && enabledInterrupt |=> s.cause[`RCR_BIT_IDLE])
      else $error("idle wake flag not set");

   // Reset requests
   trap_reset_req_a: assert property (@(posedge clock) disable iff (!rstn)
      events.trapConflict |=> deviceReset)
      else $error("no reset on trap conflict");
   mismatch_reset_req_a: assert property (@(posedge clock) disable iff (!rstn)
      events.configMismatch |=> deviceReset)
      else $error("no reset on mismatch");
   soft_reset_req_a: assert property (@(posedge clock) disable iff (!rstn)
      events.resetInstr |=> deviceReset)
      else $error("no reset on reset instruction");
   timeout_reset_req_a: assert property (@(posedge clock) disable iff (!rstn)
      events.watchdogTimeout |=> deviceReset)
      else $error("no reset on watchdog timeout");
   pin_reset_req_a: assert property (@(posedge clock) disable iff (!rstn)
      events.masterClear |=> deviceReset)
      else $error("no reset on master clear");
   quiet_no_reset_a: assert property (@(posedge clock) disable iff (!rstn)
      events == '0 && !s.pinSync[1] |=> !deviceReset)
      else $error("reset without cause");

   // Power-save modes
   run_clock_a: assert property (@(posedge clock) disable iff (!rstn)
      s.mode == RCR_RUN |-> sysClockRun && cpuRun)
      else $error("clock or processor stopped in run");
   idle_clock_a: assert property (@(posedge clock) disable iff (!rstn)
      s.mode == RCR_IDLE |-> sysClockRun && !cpuRun)
      else $error("idle clocks wrong");
   sleep_entry_a: assert property (@(posedge clock) disable iff (!rstn)
      s.mode == RCR_RUN && enterSleep |=> s.mode == RCR_SLEEP)
      else $error("sleep not entered");
   idle_entry_a: assert property (@(posedge clock) disable iff (!rstn)
      s.mode == RCR_RUN && !enterSleep && enterIdle |=> s.mode == RCR_IDLE)
      else $error("idle not entered");
   run_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      s.mode == RCR_RUN && !enterSleep && !enterIdle |=> s.mode == RCR_RUN)
      else $error("run left without request");
   wake_timeout_a: assert property (@(posedge clock) disable iff (!rstn)
      s.mode != RCR_RUN && events.watchdogTimeout |=> s.mode == RCR_RUN)
      else $error("no wake on watchdog timeout");
   wake_event_a: assert property (@(posedge clock) disable iff (!rstn)
      s.mode != RCR_RUN && events != '0 |=> s.mode == RCR_RUN)
      else $error("no wake on reset event");
   pin_wake_a: assert property (@(posedge clock) disable iff (!rstn)
      s.mode != RCR_RUN && s.pinSync[1] |=> s.mode == RCR_RUN)
      else $error("no wake on master clear");
   sleep_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      s.mode == RCR_SLEEP && !enabledInterrupt && events == '0 && !s.pinSync[1]
      |=> s.mode == RCR_SLEEP)
      else $error("sleep left without wake event");
   idle_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      s.mode == RCR_IDLE && !enabledInterrupt && events == '0 && !s.pinSync[1]
      |=> s.mode == RCR_IDLE)
      else $error("idle left without wake event");
   flash_standby_a: assert property (@(posedge clock) disable iff (!rstn)
      s.mode == RCR_SLEEP |-> flashRegStandby == !s.cause[`RCR_BIT_FLASH_REG])
      else $error("flash regulator standby wrong");
   awake_active_a: assert property (@(posedge clock) disable iff (!rstn)
      s.mode != RCR_SLEEP |-> !coreRegStandby && !flashRegStandby)
      else $error("regulator in standby while awake");

   // Register reads and interrupt status
   rdata_idle_a: assert property (@(posedge clock) disable iff (!rstn)
      !bus.rd |=> rdata == 16'h0000)
      else $error("read data without read");
   rdata_cause_a: assert property (@(posedge clock) disable iff (!rstn)
      bus.rd && bus.addr == `RCR_ADDR_CAUSE |=> rdata == $past(s.cause))
      else $error("cause read wrong");
   rdata_stat_a: assert property (@(posedge clock) disable iff (!rstn)
      bus.rd && bus.addr == `RCR_ADDR_IRQ_STAT |=> rdata == $past(s.irqStat))
      else $error("status read wrong");
   rdata_mode_a: assert property (@(posedge clock) disable iff (!rstn)
      bus.rd && bus.addr == `RCR_ADDR_MODE |=> rdata == {14'h0000, $past(s.mode)})
      else $error("mode read wrong");
   reserved_zero_a: assert property (@(posedge clock) disable iff (!rstn)
      (s.cause & ~`RCR_CAUSE_WMASK) == 16'h0000)
      else $error("unimplemented cause bit set");
   irq_stat_set_a: assert property (@(posedge clock) disable iff (!rstn)
      events.watchdogTimeout |=> s.irqStat[`RCR_BIT_WDT_TO])
      else $error("timeout status not set");
   irq_trap_stat_a: assert property (@(posedge clock) disable iff (!rstn)
      events.trapConflict |=> s.irqStat[`RCR_BIT_TRAP])
      else $error("trap status not set");
   irq_level_a: assert property (@(posedge clock) disable iff (!rstn)
      irq == |(s.irqStat & s.irqMask))
      else $error("interrupt level wrong");
   irq_clear_a: assert property (@(posedge clock) disable iff (!rstn)
      bus.wr && bus.addr == `RCR_ADDR_IRQ_STAT && events == '0 && !s.pinSync[1]
      && s.mode == RCR_RUN |=> (s.irqStat & $past(bus.wdata)) == 16'h0000)
      else $error("interrupt status not cleared");
endmodule
`default_nettype wire

// ---- src/rcr_defs.svh ----
// Register offsets, field positions, reset values, write mask and watchdog setting of the reset cause recorder
`ifndef RCR_DEFS_SVH
`define RCR_DEFS_SVH
`define RCR_ADDR_CAUSE     4'h0
`define RCR_ADDR_IRQ_STAT  4'h1
`define RCR_ADDR_IRQ_MASK  4'h2
`define RCR_ADDR_MODE      4'h3
`define RCR_BIT_TRAP       15
`define RCR_BIT_ILLEGAL    14
`define RCR_BIT_FLASH_REG  11
`define RCR_BIT_CFG_MIS    9
`define RCR_BIT_CORE_REG   8
`define RCR_BIT_PIN        7
`define RCR_BIT_SOFT       6
`define RCR_BIT_WDT_EN     5
`define RCR_BIT_WDT_TO     4
`define RCR_BIT_SLEEP      3
`define RCR_BIT_IDLE       2
`define RCR_BIT_BROWNOUT   1
`define RCR_BIT_POWERON    0
`define RCR_CAUSE_POR      16'h0003
`define RCR_CAUSE_WMASK    16'hcbff
`define RCR_WDT_CFG_ON     2'h3
`endif

// ---- src/rcr_pkg.sv ----
// Types shared by the reset cause recorder
package rcr_pkg;
   typedef enum logic [1:0] {RCR_RUN, RCR_IDLE, RCR_SLEEP} rcr_mode_type;
   typedef struct packed {
      logic trapConflict;
      logic illegalOp;
      logic configMismatch;
      logic masterClear;
      logic resetInstr;
      logic watchdogTimeout;
      logic brownout;
      logic powerOn;
   } rcr_event_type;
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } rcr_bus_type;
   typedef struct packed {
      logic [15:0]  cause;
      logic [15:0]  irqStat;
      logic [15:0]  irqMask;
      rcr_mode_type mode;
      logic [15:0]  rdata;
      logic         irq;
      logic         wdtRun;
      logic         sysClockRun;
      logic         cpuRun;
      logic         coreRegStandby;
      logic         flashRegStandby;
      logic         deviceReset;
      logic [1:0]   pinSync;
      logic         porDone;
   } rcr_state_type;
endpackage

// ---- bench/reset_cause_recorder_test.sv ----
// Self-checking testbench of the reset cause recorder
`timescale 1ns/1ns
`default_nettype none
module reset_cause_recorder_test
   import rcr_pkg::*;
;
   logic          clock;
   logic          rstn;
   rcr_bus_type   bus;
   logic [15:0]   rdata;
   rcr_event_type events;
   logic          masterClearPin;
   logic [1:0]    cfg;
   logic          enterSleep, enterIdle, wake;
   logic          irq, wdtRun, sysClockRun, cpuRun, coreRegStandby, flashRegStandby, deviceReset;
   int            fail_count, checks, cycles, i;
   logic [15:0]   q, d;
   int            pos[8] = '{15, 14, 9, 7, 6, 4, 1, 0};
   logic [3:0]    adr[5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9};
   logic [15:0]   rv[5]  = '{16'h0003, 16'h0003, 16'h0000, 16'h0000, 16'h0000};

   reset_cause_recorder u_reset_cause_recorder (
      .clock(clock), .rstn(rstn), .bus(bus), .rdata(rdata), .events(events),
      .masterClearPin(masterClearPin), .watchdogConfigField(cfg),
      .enterSleep(enterSleep), .enterIdle(enterIdle), .enabledInterrupt(wake),
      .irq(irq), .wdtRun(wdtRun), .sysClockRun(sysClockRun), .cpuRun(cpuRun),
      .coreRegStandby(coreRegStandby), .flashRegStandby(flashRegStandby),
      .deviceReset(deviceReset));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Expected cause flag of event n
   function automatic logic [15:0] flag_of(input int n);
      return 16'h0001 << pos[n];
   endfunction

   // Clock, processor, core standby, flash standby for mode m and cause c
   function automatic logic [3:0] power_of(input logic [1:0] m, input logic [15:0] c);
      return {m != 2'h2, m == 2'h0, m == 2'h2 && !c[8], m == 2'h2 && !c[11]};
   endfunction

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clock);
      bus.addr  <= a;
      bus.wdata <= v;
      bus.wr    <= 1'b1;
      @(posedge clock);
      bus.wr    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clock);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge clock);
      bus.rd   <= 1'b0;
      @(negedge clock);
      v = rdata;
   endtask

   // One-cycle event pulse, ends where the response has settled
   task automatic pulse(input int n);
      @(posedge clock);
      events <= rcr_event_type'(8'h80 >> n);
      @(posedge clock);
      events <= '0;
      @(negedge clock);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles > 5000) begin
         fail_count++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rstn = 1'b0; bus = '0; events = '0; masterClearPin = 1'b0; cfg = 2'h0;
      enterSleep = 1'b0; enterIdle = 1'b0; wake = 1'b0;
      fail_count = 0; checks = 0; cycles = 0;
      void'($urandom(32'h2803));
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      for (i = 0; i < 5; i++) begin
         rd(adr[i], q);
         chk(q, rv[i]);
      end
      for (i = 0; i < 8; i++) begin
         wr(4'h0, 16'h0000);
         pulse(i);
         chk(deviceReset, {15'h0000, i < 7});
         rd(4'h0, q);
         chk(q, flag_of(i));
      end
      repeat (16) begin
         d = 16'($urandom) & 16'hcbf3;
         wr(4'h0, d);
         @(negedge clock);
         chk(deviceReset, 1'b0);
         chk(wdtRun, d[5]);
         rd(4'h0, q);
         chk(q, d);
      end
      @(posedge clock) cfg <= 2'h3;
      wr(4'h0, 16'h0000);
      @(negedge clock);
      chk(wdtRun, 1'b1);
      wr(4'h2, 16'h0010);
      wr(4'h1, 16'hffff);
      pulse(0);
      rd(4'h1, q);
      chk(q, 16'h8000);
      chk(irq, 1'b0);
      pulse(5);
      @(negedge clock);
      chk(irq, 1'b1);
      wr(4'h1, 16'h0010);
      repeat (2) @(negedge clock);
      chk(irq, 1'b0);
      @(posedge clock) masterClearPin <= 1'b1;
      @(posedge clock) masterClearPin <= 1'b0;
      repeat (4) @(posedge clock);
      rd(4'h0, q);
      chk(q & 16'h0080, 16'h0080);
      wr(4'h0, 16'h0100);
      @(posedge clock) enterSleep <= 1'b1;
      @(posedge clock) enterSleep <= 1'b0;
      repeat (2) @(negedge clock);
      chk({sysClockRun, cpuRun, coreRegStandby, flashRegStandby}, power_of(2'h2, 16'h0100));
      rd(4'h3, q);
      chk(q, 16'h0002);
      @(posedge clock) wake <= 1'b1;
      @(posedge clock) wake <= 1'b0;
      repeat (2) @(negedge clock);
      chk({sysClockRun, cpuRun, coreRegStandby, flashRegStandby}, power_of(2'h0, 16'h0100));
      rd(4'h0, q);
      chk(q & 16'h0008, 16'h0008);
      @(posedge clock) enterIdle <= 1'b1;
      @(posedge clock) enterIdle <= 1'b0;
      repeat (2) @(negedge clock);
      chk({sysClockRun, cpuRun, coreRegStandby, flashRegStandby}, power_of(2'h1, 16'h0100));
      pulse(5);
      @(negedge clock);
      chk(cpuRun, 1'b1);
      summarize();
   end
endmodule
`default_nettype wire
